// *** core/pnp_pkg.sv ***
/*
  Constants, state codes and carrier types shared by the host port and its window memory.
  Assumes an ISA-style I/O bus whose strobes and address are synchronised inside the port.
*/
// How it works
// - address port sits at fixed I/O 0x279 and selects the configuration register.
// - write-data port at fixed I/O 0xA79 writes the selected configuration register.
// - read-data port is movable within 0x203..0x3FF and returns the selected register.
// - read port location is programmed as the port address shifted right by two.
// - four-state machine starts in key-wait; board inactive and unconfigured at reset.
// - only the exact 34-write key sequence moves key-wait to sleep.
// - reset command clears configuration registers and returns to key-wait.
// - wake command in sleep moves the board to isolation.
// - isolation moves to configuration; resource writes accepted only in configuration.
// - full 16-bit decode, so both base address bytes are programmed.
// - base address registers read back through the read-data port.
// - base address decodes only while activate is set; writing activate returns the machine to key-wait.
// - once active, board registers decode at fixed offsets from the base.
// - base address kept only in volatile flops, lost on reset.
// - index and data registers reach all 180 timing-controller registers.
// - windowed write: index first, then data write forwarded to that target.
// - windowed read: index first, then data read returns that target.
package pnp_pkg;
  localparam logic [15:0] ADDR_PORT = 16'h0279;
  localparam logic [15:0] WDATA_PORT = 16'h0a79;
  localparam logic [15:0] RDPORT_MIN = 16'h0203;
  localparam logic [15:0] RDPORT_MAX = 16'h03ff;
  localparam logic [5:0] KEY_LEN = 6'h22;
  localparam logic [5:0] KEY_ZEROS = 6'h02;
  localparam logic [7:0] KEY_SEED = 8'h6a;
  // configuration register indexes
  localparam logic [7:0] CR_RDPORT = 8'h00;
  localparam logic [7:0] CR_CTRL = 8'h02;
  localparam logic [7:0] CR_WAKE = 8'h03;
  localparam logic [7:0] CR_CSN = 8'h06;
  localparam logic [7:0] CR_ACTIVATE = 8'h30;
  localparam logic [7:0] CR_BASE_HI = 8'h60;
  localparam logic [7:0] CR_BASE_LO = 8'h61;
  localparam int CTRL_RESET_BIT = 0;
  localparam int CTRL_WAITKEY_BIT = 1;
  // board register offsets from the assigned base
  localparam logic [15:0] OFS_WIN_INDEX = 16'h0000;
  localparam logic [15:0] OFS_WIN_DATA = 16'h0002;
  localparam int WIN_REGS = 180;
  localparam logic [7:0] WIN_LAST = 8'hb3;

  typedef enum logic [3:0] {
    ST_WAIT4KEY = 4'b0001,
    ST_SLEEP = 4'b0010,
    ST_ISOLATE = 4'b0100,
    ST_CONFIG = 4'b1000
  } cfg_state_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] wdata;
    logic iow;
    logic ior;
  } bus_pins_t;

  typedef struct packed {
    logic we;
    logic [7:0] addr;
    logic [15:0] wdata;
  } win_req_t;
endpackage : pnp_pkg

// *** core/win_ram.sv ***
/*
  Storage standing in for the 180 windowed timing-controller registers.
  Assumes one write port and a read address that is steady between accesses.
*/
`timescale 1ns/1ps
`default_nettype none
module win_ram (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire pnp_pkg::win_req_t req,
  input wire logic [7:0] raddr,
  output logic [15:0] rdata
);
  logic [15:0] mem [pnp_pkg::WIN_REGS];
  logic [15:0] rdata_q;

  always_ff @(posedge clk) begin
    if (ce && req.we) begin
      mem[req.addr] <= req.wdata;
    end
  end

  // out-of-range index reads zero instead of an undefined word
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 16'h0000;
    end else if (ce) begin
      rdata_q <= (raddr <= pnp_pkg::WIN_LAST) ? mem[raddr] : 16'h0000;
    end
  end

  assign rdata = rdata_q;
endmodule : win_ram
`default_nettype wire

// *** core/pnp_host_port.sv ***
/*
  Plug and Play configuration logic and windowed register access for the host I/O bus.
  Assumes asynchronous bus strobes held for several clocks; data pins are split in/out/enable.
*/
`timescale 1ns/1ps
`default_nettype none
module pnp_host_port (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [15:0] io_addr,
  input wire logic [15:0] io_data_in,
  input wire logic io_wr,
  input wire logic io_rd,
  output logic [15:0] io_data_out,
  output logic io_data_oe_n,
  output logic board_active,
  output logic [3:0] cfg_state
);
  typedef struct packed {
    pnp_pkg::bus_pins_t s1;
    pnp_pkg::bus_pins_t s2;
    logic iow3;
    pnp_pkg::cfg_state_t st;
    logic [5:0] key_idx;
    logic [7:0] lfsr;
    logic [7:0] cfg_addr;
    logic [7:0] rdport;
    logic [7:0] csn;
    logic [7:0] base_hi;
    logic [7:0] base_lo;
    logic act;
    logic [7:0] win_idx;
    logic [15:0] dout;
    logic doe_n;
  } core_t;

  core_t st_q;
  core_t st_d;
  pnp_pkg::win_req_t win_req;
  logic [15:0] win_rdata;
  logic wr_edge;
  logic addr_wr;
  logic cfg_wr;
  logic idx_wr;
  logic win_wr;
  logic key_match;
  logic rd_cfg_hit;
  logic rd_win_hit;
  logic [15:0] base;
  logic [15:0] rdport_addr;
  logic [7:0] key_expect;
  logic [7:0] cfg_rdata;

  win_ram u_win_ram (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .req(win_req),
    .raddr(st_q.win_idx),
    .rdata(win_rdata)
  );

  // decode, from the second synchroniser stage, with iow3 delaying the write strobe for edge detection
  always_comb begin
    base = {st_q.base_hi, st_q.base_lo};
    rdport_addr = {6'h00, st_q.rdport, 2'b11};
    wr_edge = st_q.s2.iow && !st_q.iow3;
    addr_wr = wr_edge && (st_q.s2.addr == pnp_pkg::ADDR_PORT);
    cfg_wr = wr_edge && (st_q.s2.addr == pnp_pkg::WDATA_PORT);
    idx_wr = wr_edge && st_q.act
      && (st_q.s2.addr == 16'(base + pnp_pkg::OFS_WIN_INDEX));
    win_wr = wr_edge && st_q.act
      && (st_q.s2.addr == 16'(base + pnp_pkg::OFS_WIN_DATA));
    key_expect = (st_q.key_idx < pnp_pkg::KEY_ZEROS) ? 8'h00 : st_q.lfsr;
    key_match = (st_q.s2.wdata[7:0] == key_expect);
    // a port below the legal window is treated as unassigned
    rd_cfg_hit = st_q.s2.ior
      && (st_q.st == pnp_pkg::ST_ISOLATE || st_q.st == pnp_pkg::ST_CONFIG)
      && (rdport_addr >= pnp_pkg::RDPORT_MIN) && (rdport_addr <= pnp_pkg::RDPORT_MAX)
      && (st_q.s2.addr == rdport_addr);
    rd_win_hit = st_q.s2.ior && st_q.act
      && (st_q.s2.addr == 16'(base + pnp_pkg::OFS_WIN_DATA));
    unique case (st_q.cfg_addr)
      pnp_pkg::CR_RDPORT: cfg_rdata = st_q.rdport;
      pnp_pkg::CR_CSN: cfg_rdata = st_q.csn;
      pnp_pkg::CR_ACTIVATE: cfg_rdata = {7'h00, st_q.act};
      pnp_pkg::CR_BASE_HI: cfg_rdata = st_q.base_hi;
      pnp_pkg::CR_BASE_LO: cfg_rdata = st_q.base_lo;
      default: cfg_rdata = 8'h00;
    endcase
    win_req.we = win_wr && (st_q.win_idx <= pnp_pkg::WIN_LAST);
    win_req.addr = st_q.win_idx;
    win_req.wdata = st_q.s2.wdata;
  end

  always_comb begin
    st_d = st_q;
    st_d.s1 = '{addr: io_addr, wdata: io_data_in, iow: io_wr, ior: io_rd};
    st_d.s2 = st_q.s1;
    st_d.iow3 = st_q.s2.iow;
    if (addr_wr) begin
      st_d.cfg_addr = st_q.s2.wdata[7:0];
    end
    // key detector: any wrong byte restarts it, a zero counts as the first lead-in
    if (addr_wr && st_q.st == pnp_pkg::ST_WAIT4KEY) begin
      if (key_match) begin
        st_d.key_idx = 6'(st_q.key_idx + 6'h01);
        if (st_q.key_idx >= pnp_pkg::KEY_ZEROS) begin
          st_d.lfsr = {st_q.lfsr[1] ^ st_q.lfsr[0], st_q.lfsr[7:1]};
        end
        if (st_q.key_idx == 6'(pnp_pkg::KEY_LEN - 6'h01)) begin
          st_d.st = pnp_pkg::ST_SLEEP;
          st_d.key_idx = 6'h00;
          st_d.lfsr = pnp_pkg::KEY_SEED;
        end
      end else begin
        st_d.key_idx = (st_q.s2.wdata[7:0] == 8'h00) ? 6'h01 : 6'h00;
        st_d.lfsr = pnp_pkg::KEY_SEED;
      end
    end
    if (cfg_wr && st_q.st != pnp_pkg::ST_WAIT4KEY) begin
      unique case (st_q.cfg_addr)
        pnp_pkg::CR_RDPORT: begin
          if (st_q.st == pnp_pkg::ST_ISOLATE || st_q.st == pnp_pkg::ST_CONFIG) begin
            st_d.rdport = st_q.s2.wdata[7:0];
          end
        end
        pnp_pkg::CR_CTRL: begin
          if (st_q.s2.wdata[pnp_pkg::CTRL_RESET_BIT]) begin
            st_d.rdport = 8'h00;
            st_d.csn = 8'h00;
            st_d.base_hi = 8'h00;
            st_d.base_lo = 8'h00;
            st_d.act = 1'b0;
            st_d.st = pnp_pkg::ST_WAIT4KEY;
          end else if (st_q.s2.wdata[pnp_pkg::CTRL_WAITKEY_BIT]) begin
            st_d.st = pnp_pkg::ST_WAIT4KEY;
          end
        end
        pnp_pkg::CR_WAKE: begin
          if (st_q.st == pnp_pkg::ST_SLEEP && st_q.s2.wdata[7:0] == st_q.csn) begin
            st_d.st = pnp_pkg::ST_ISOLATE;
          end
        end
        pnp_pkg::CR_CSN: begin
          if (st_q.st == pnp_pkg::ST_ISOLATE || st_q.st == pnp_pkg::ST_CONFIG) begin
            st_d.csn = st_q.s2.wdata[7:0];
            st_d.st = pnp_pkg::ST_CONFIG;
          end
        end
        pnp_pkg::CR_ACTIVATE: begin
          if (st_q.st == pnp_pkg::ST_CONFIG) begin
            st_d.act = st_q.s2.wdata[0];
            st_d.st = pnp_pkg::ST_WAIT4KEY;
          end
        end
        pnp_pkg::CR_BASE_HI: begin
          if (st_q.st == pnp_pkg::ST_CONFIG) begin
            st_d.base_hi = st_q.s2.wdata[7:0];
          end
        end
        pnp_pkg::CR_BASE_LO: begin
          if (st_q.st == pnp_pkg::ST_CONFIG) begin
            st_d.base_lo = st_q.s2.wdata[7:0];
          end
        end
        default: begin
        end
      endcase
    end
    if (idx_wr) begin
      st_d.win_idx = st_q.s2.wdata[7:0];
    end
    // data driven as long as the synchronised read strobe and decode hold
    st_d.doe_n = !(rd_cfg_hit || rd_win_hit);
    if (rd_cfg_hit) begin
      st_d.dout = {8'h00, cfg_rdata};
    end else if (rd_win_hit) begin
      st_d.dout = win_rdata;
    end else begin
      st_d.dout = 16'h0000;
    end
  end

  // reset clears the port flops except st, lfsr and doe_n (key-wait, seed, high), not the window memory: base and activation live only in these flops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
      st_q.st <= pnp_pkg::ST_WAIT4KEY;
      st_q.lfsr <= pnp_pkg::KEY_SEED;
      st_q.doe_n <= 1'b1;
    end else if (ce) begin
      st_q <= st_d;
    end
  end

  assign io_data_out = st_q.dout;
  assign io_data_oe_n = st_q.doe_n;
  assign board_active = st_q.act;
  assign cfg_state = st_q.st;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  AST_KEY_TO_SLEEP: assert property (
    ce && addr_wr && st_q.st == pnp_pkg::ST_WAIT4KEY && key_match
    && st_q.key_idx == 6'h21 |=> st_q.st == pnp_pkg::ST_SLEEP)
    else $error("full key did not reach sleep");
  AST_BAD_KEY_STAYS: assert property (
    ce && addr_wr && st_q.st == pnp_pkg::ST_WAIT4KEY && !key_match
    |=> st_q.st == pnp_pkg::ST_WAIT4KEY && st_q.key_idx <= 6'h01)
    else $error("wrong key byte did not restart");
  AST_WAIT_SILENT: assert property (
    st_q.st == pnp_pkg::ST_WAIT4KEY && !st_q.act ##1 st_q.st == pnp_pkg::ST_WAIT4KEY
    |=> io_data_oe_n)
    else $error("inactive board drove the data bus");
  AST_RESET_CMD: assert property (
    ce && cfg_wr && st_q.st != pnp_pkg::ST_WAIT4KEY && st_q.cfg_addr == pnp_pkg::CR_CTRL
    && st_q.s2.wdata[0] |=> st_q.st == pnp_pkg::ST_WAIT4KEY && base == 16'h0000 && !st_q.act)
    else $error("reset command left configuration behind");
  AST_WAKE: assert property (
    ce && cfg_wr && st_q.st == pnp_pkg::ST_SLEEP && st_q.cfg_addr == pnp_pkg::CR_WAKE
    && st_q.s2.wdata[7:0] == st_q.csn |=> st_q.st == pnp_pkg::ST_ISOLATE)
    else $error("wake did not enter isolation");
  AST_BASE_ONLY_CONFIG: assert property (
    st_q.st != pnp_pkg::ST_CONFIG && !(ce && cfg_wr && st_q.cfg_addr == pnp_pkg::CR_CTRL)
    |=> $stable(base))
    else $error("base changed outside configuration");
  AST_ACTIVATE: assert property (
    ce && cfg_wr && st_q.st == pnp_pkg::ST_CONFIG && st_q.cfg_addr == pnp_pkg::CR_ACTIVATE
    |=> st_q.st == pnp_pkg::ST_WAIT4KEY && board_active == $past(st_q.s2.wdata[0]))
    else $error("activate did not take effect");
  AST_CFG_READ: assert property (
    ce && rd_cfg_hit |=> !io_data_oe_n && io_data_out[7:0] == $past(cfg_rdata))
    else $error("read port did not answer");
  AST_IDX_HOLD: assert property (
    !(ce && idx_wr) |=> $stable(st_q.win_idx))
    else $error("window index moved without a write");
  AST_WIN_WRITE: assert property (
    ce && win_wr && st_q.win_idx <= pnp_pkg::WIN_LAST
    |=> u_win_ram.mem[$past(st_q.win_idx)] == $past(st_q.s2.wdata))
    else $error("window write not forwarded");

  COV_SLEEP: cover property (st_q.st == pnp_pkg::ST_WAIT4KEY ##1 st_q.st == pnp_pkg::ST_SLEEP);
  COV_CONFIG: cover property (st_q.st == pnp_pkg::ST_CONFIG);
  COV_ACTIVE: cover property (!board_active ##1 board_active);
  COV_WIN_READ: cover property (rd_win_hit ##1 !io_data_oe_n);
endmodule : pnp_host_port
`default_nettype wire

// *** bench/isa_host.sv ***
/*
  Host processor model: drives I/O write and read cycles on the board's bus pins.
  Assumes the clock of the port under test; strobes change just after a rising edge.
*/
`timescale 1ns/1ps
`default_nettype none
module isa_host (
  input wire logic clk,
  input wire logic [15:0] io_data_out,
  input wire logic io_data_oe_n,
  output logic [15:0] io_addr,
  output wire logic [15:0] io_data_in,
  output logic io_wr,
  output logic io_rd
);
  logic [15:0] drv_q = 16'h0000;
  initial begin
    io_addr = 16'h0000;
    io_wr = 1'b0;
    io_rd = 1'b0;
  end
  // released bus shows the inverse of the last value, never a held copy
  assign io_data_in = io_data_oe_n ? drv_q : io_data_out;
  // address and data held across the strobe and its low phase
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    io_addr <= a;
    drv_q <= d;
    io_wr <= 1'b1;
    repeat (5) @(posedge clk);
    io_wr <= 1'b0;
    repeat (5) @(posedge clk);
    drv_q <= ~d;
  endtask : wr
  // read data taken at the edge that shows the enable low
  task automatic rd(input logic [15:0] a, output logic hit, output logic [15:0] d);
    int n;
    @(posedge clk);
    io_addr <= a;
    io_rd <= 1'b1;
    hit = 1'b0;
    d = 16'h0000;
    for (n = 0; n < 8 && !hit; n++) begin
      @(posedge clk);
      if (io_data_oe_n === 1'b0) begin
        hit = 1'b1;
        d = io_data_out;
      end
    end
    io_rd <= 1'b0;
    repeat (6) @(posedge clk);
  endtask : rd
endmodule : isa_host
`default_nettype wire

// *** bench/testbench.sv ***
/*
  Self-checking bench for the host port, with a behavioural model of the board.
  Assumes the host model drives every bus cycle; clock enable held high.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  wire logic [15:0] io_addr, io_data_in, io_data_out;
  wire logic io_wr, io_rd, io_data_oe_n, board_active;
  wire logic [3:0] cfg_state;
  int failures = 0, n_checks = 0, st = 0, kidx = 0, i;
  integer seed = 32'h4c63e1a1;
  logic [7:0] key [34];
  logic [7:0] idx = 8'h00, rdp = 8'h00, wi = 8'h00;
  logic [15:0] base = 16'h0000, mem [180], p, v;
  logic act = 1'b0, hit;
  initial forever #2 clk = ~clk;
  isa_host u_host (.clk(clk), .io_data_out(io_data_out), .io_data_oe_n(io_data_oe_n),
    .io_addr(io_addr), .io_data_in(io_data_in), .io_wr(io_wr), .io_rd(io_rd));
  pnp_host_port u_dut (.clk(clk), .rst_n(rst_n), .ce(1'b1), .io_addr(io_addr),
    .io_data_in(io_data_in), .io_wr(io_wr), .io_rd(io_rd), .io_data_out(io_data_out),
    .io_data_oe_n(io_data_oe_n), .board_active(board_active), .cfg_state(cfg_state));
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : finish_test
  task automatic bw(input logic [15:0] a, input logic [15:0] d);
    u_host.wr(a, d);
    if (a == pnp_pkg::ADDR_PORT) begin
      idx = d[7:0];
      if (st == 0) begin
        kidx = (d[7:0] == key[kidx]) ? kidx + 1 : (d[7:0] == 8'h00);
        if (kidx == 34) st = 1;
      end
    end else if (a == pnp_pkg::WDATA_PORT && st != 0) begin
      case (idx)
        pnp_pkg::CR_RDPORT: if (st >= 2) rdp = d[7:0];
        pnp_pkg::CR_CTRL: begin
          if (d[0]) {base, rdp, act} = '0;
          if (d[1:0] != 2'b00) st = 0;
        end
        pnp_pkg::CR_WAKE: if (st == 1 && d[7:0] == 8'h00) st = 2;
        pnp_pkg::CR_CSN: if (st == 2) st = 3;
        pnp_pkg::CR_ACTIVATE: if (st == 3) {act, st} = {d[0], 32'd0};
        pnp_pkg::CR_BASE_HI: if (st == 3) base[15:8] = d[7:0];
        pnp_pkg::CR_BASE_LO: if (st == 3) base[7:0] = d[7:0];
        default: ;
      endcase
      if (st == 0) kidx = 0;
    end else if (act && a == base + pnp_pkg::OFS_WIN_INDEX) wi = d[7:0];
    else if (act && a == base + pnp_pkg::OFS_WIN_DATA && wi < 180) mem[wi] = d;
    check("cfg_state", {12'h000, cfg_state}, 16'h0001 << st);
    check("board_active", {15'h0000, board_active}, {15'h0000, act});
  endtask : bw
  task automatic br(input logic [15:0] a);
    logic [15:0] e;
    logic eh;
    u_host.rd(a, hit, v);
    eh = act && a == base + pnp_pkg::OFS_WIN_DATA;
    e = (wi < 180) ? mem[wi] : 16'h0000;
    if (st >= 2 && a == {6'h00, rdp, 2'b11} && a >= pnp_pkg::RDPORT_MIN) begin
      eh = 1'b1;
      e = {8'h00, (idx == pnp_pkg::CR_BASE_HI) ? base[15:8] : base[7:0]};
    end
    check("read hit", {15'h0000, hit}, {15'h0000, eh});
    if (eh) check("read data", v, e);
  endtask : br
  task automatic cfg(input logic [7:0] r, input logic [7:0] d);
    bw(pnp_pkg::ADDR_PORT, {8'h00, r});
    bw(pnp_pkg::WDATA_PORT, {8'h00, d});
  endtask : cfg
  task automatic to_config();
    for (int k = 0; k < 34; k++) bw(pnp_pkg::ADDR_PORT, {8'h00, key[k]});
    cfg(pnp_pkg::CR_WAKE, 8'h00);
    cfg(pnp_pkg::CR_BASE_HI, 8'h55);
    cfg(pnp_pkg::CR_CSN, 8'h00);
    // legal read port: both low bits set, inside the window
    p = 16'h0203 + 16'(($unsigned($random(seed)) % 128) * 4);
    cfg(pnp_pkg::CR_RDPORT, p[9:2]);
  endtask : to_config
  initial begin
    #200000;
    failures++;
    finish_test();
  end
  initial begin
    key[0] = 8'h00;
    key[1] = 8'h00;
    key[2] = pnp_pkg::KEY_SEED;
    for (i = 3; i < 34; i++) key[i] = {key[i-1][1] ^ key[i-1][0], key[i-1][7:1]};
    for (i = 0; i < 180; i++) mem[i] = 16'h0000;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    check("reset state", {12'h000, cfg_state}, 16'h0001);
    check("reset oe_n", {15'h0000, io_data_oe_n}, 16'h0001);
    cfg(pnp_pkg::CR_ACTIVATE, 8'h01);
    for (i = 0; i < 10; i++) bw(pnp_pkg::ADDR_PORT, {8'h00, key[i]});
    bw(pnp_pkg::ADDR_PORT, 16'h00ff);
    $display("test key and ignored writes done");
    to_config();
    cfg(pnp_pkg::CR_BASE_LO, 8'h12);
    cfg(pnp_pkg::CR_CTRL, 8'h01);
    to_config();
    bw(pnp_pkg::ADDR_PORT, {8'h00, pnp_pkg::CR_BASE_HI});
    br(p);
    br(p ^ 16'h0004);
    $display("test reset command done");
    cfg(pnp_pkg::CR_BASE_HI, 8'h40 | 8'($random(seed) & 8'h3f));
    cfg(pnp_pkg::CR_BASE_LO, 8'($random(seed) & 8'hf0));
    br(p);
    bw(pnp_pkg::ADDR_PORT, {8'h00, pnp_pkg::CR_BASE_HI});
    br(p);
    br(base + pnp_pkg::OFS_WIN_DATA);
    cfg(pnp_pkg::CR_ACTIVATE, 8'h01);
    br(p);
    $display("test base assignment done");
    // host keeps the model memory as its shadow of the windowed targets, each read back twice
    for (i = 0; i < 8; i++) begin
      v = (i == 0) ? 16'h0000 : (i == 1) ? 16'(pnp_pkg::WIN_LAST) : (i == 2) ? 16'd180 :
        16'($unsigned($random(seed)) % 180);
      bw(base + pnp_pkg::OFS_WIN_INDEX, v);
      bw(base + pnp_pkg::OFS_WIN_DATA, 16'($random(seed)));
      br(base + pnp_pkg::OFS_WIN_DATA);
      br(base + pnp_pkg::OFS_WIN_DATA);
    end
    $display("test window access done");
    for (i = 0; i < 34; i++) bw(pnp_pkg::ADDR_PORT, {8'h00, key[i]});
    cfg(pnp_pkg::CR_CTRL, 8'h02);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    {st, base, rdp, act} = '0;
    check("active after reset", {15'h0000, board_active}, 16'h0000);
    br(16'h0002);
    $display("test power cycle done");
    finish_test();
  end
endmodule : testbench
`default_nettype wire
